/* dap_pkg.sv */
// package: assembly layout, register map and carrier types of the drive assembly packer
package dap_pkg;

  // ==========================================================================
  // assembly layout
  // ==========================================================================
  localparam int          DAP_ASM_BYTES   = 26;      // bytes 0..25 in both directions
  localparam int          DAP_PARAM_WORDS = 10;      // configurable parameter words
  localparam logic [7:0]  DAP_OUT_INST    = 8'h7B;   // output assembly instance 123
  localparam logic [7:0]  DAP_IN_INST     = 8'hAD;   // input assembly instance 173
  localparam logic [4:0]  DAP_LAST_IDX    = 5'h19;   // byte 25 closes a frame
  localparam int          DAP_BYTE_STATE  = 1;       // drive state code byte
  localparam int          DAP_BYTE_SPEED  = 2;       // speed word, low byte first
  localparam int          DAP_BYTE_TORQUE = 4;       // torque word, low byte first
  localparam int          DAP_BYTE_PARAM  = 6;       // first parameter word

  // output byte 0 bit positions
  localparam int DAP_BIT_RUN_FWD   = 0;
  localparam int DAP_BIT_RUN_REV   = 1;
  localparam int DAP_BIT_FAULT_RST = 2;
  localparam int DAP_BIT_NET_CTL   = 5;
  localparam int DAP_BIT_NET_REF   = 6;

  // ==========================================================================
  // register map
  // ==========================================================================
  localparam logic [3:0]  DAP_REG_CTRL    = 4'h0;    // enables
  localparam logic [3:0]  DAP_REG_STAT    = 4'h4;    // counters and flags
  localparam logic [3:0]  DAP_REG_INST    = 4'h8;    // instance numbers
  localparam logic [1:0]  DAP_CTRL_RESET  = 2'h3;    // both directions enabled
  localparam int          DAP_STAT_LENERR = 16;      // sticky framing error, write 1 clears

  // ==========================================================================
  // carrier types
  // ==========================================================================
  typedef struct packed {
    logic                 run_forward;
    logic                 run_reverse;
    logic                 fault_reset;
    logic                 control_from_network_select;
    logic                 reference_from_network_select;
    logic [15:0]          speed_ref;
    logic [15:0]          torque_ref;
    logic [9:0][15:0]     param;                     // param[0] is word 1
  } dap_cmd_t;

  typedef struct packed {
    logic                 at_reference;              // byte 0 bit 7 down to bit 0
    logic                 ref_from_net;
    logic                 ctrl_from_net;
    logic                 ready;
    logic                 running_reverse;
    logic                 running_forward;
    logic                 warning;
    logic                 faulted;
    logic [7:0]           drive_state;
    logic [15:0]          speed_act;
    logic [15:0]          torque_act;
    logic [9:0][15:0]     param;
  } dap_sts_t;

endpackage

/* dap_skid_buf.sv */
// file: two-entry buffer with valid/ready on both sides
`timescale 1ns/100ps
module dap_skid_buf
  import dap_pkg::*;
#(
  parameter int W = 10                   // payload width
)(
  input  wire logic         mclk_i,      // system clock
  input  wire logic         reset_n_i,   // async reset, active low
  input  wire logic         in_valid_i,  // source offers a word
  output logic              in_ready_o,  // room for a word
  input  wire logic [W-1:0] in_data_i,   // word from source
  output logic              out_valid_o, // word waiting
  input  wire logic         out_ready_i, // sink takes the word
  output logic [W-1:0]      out_data_o   // head word
);

  // ==========================================================================
  // storage
  // ==========================================================================
  logic [W-1:0] mem_q [2];               // two entries, enough to cover one stall
  logic         wptr_q;                  // write slot
  logic         rptr_q;                  // read slot
  logic [1:0]   cnt_q;                   // entries held
  wire          push = in_valid_i & in_ready_o;
  wire          pop  = out_valid_o & out_ready_i;

  assign in_ready_o  = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o  = mem_q[rptr_q];

  // pointers and occupancy
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wptr_q <= 1'b0;
      rptr_q <= 1'b0;
      cnt_q  <= 2'h0;
    end
    else
    begin
      if (push) wptr_q <= ~wptr_q;
      if (pop)  rptr_q <= ~rptr_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // entries carry no reset: valid never exposes them before a write
  always_ff @(posedge mclk_i)
  begin
    if (push) mem_q[wptr_q] <= in_data_i;
  end

endmodule

/* dap_top.sv */
// file: drive process-data assembly packer, output unpack and input pack
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
module dap_top
  import dap_pkg::*;
(
  input  wire logic        mclk_i,      // 10 MHz system clock
  input  wire logic        reset_n_i,   // async reset, active low
  // output assembly byte stream from network side
  input  wire logic        rx_valid_i,  // byte present
  input  wire logic        rx_sof_i,    // byte is byte 0
  input  wire logic [7:0]  rx_data_i,   // byte value
  output logic             rx_ready_o,  // always ready
  // unpacked command to drive
  output dap_cmd_t         cmd_o,       // last complete command
  output logic             cmd_valid_o, // one-cycle pulse on update
  // drive status and input assembly stream
  input  wire dap_sts_t    sts_i,       // drive status
  input  wire logic        tx_start_i,  // pulse: send one input assembly
  output logic             tx_valid_o,  // byte present
  input  wire logic        tx_ready_i,  // receiver takes byte
  output logic [7:0]       tx_data_o,   // byte value
  output logic             tx_sof_o,    // byte is byte 0
  output logic             tx_last_o,   // byte is byte 25
  output logic             tx_busy_o,   // frame being loaded
  // register port
  input  wire logic [3:0]  reg_addr_i,  // byte address
  input  wire logic [31:0] reg_wdata_i, // write data
  input  wire logic        reg_wr_i,    // write strobe
  input  wire logic        reg_rd_i,    // read strobe
  output logic [31:0]      reg_rdata_o  // read data, cycle after strobe
);

  localparam int NB = DAP_ASM_BYTES * 8;  // frame bits

  // ==========================================================================
  // register decode
  // ==========================================================================
  logic [1:0]  ctrl_q;                    // [0] rx enable, [1] tx enable
  logic [7:0]  rx_cnt_q;                  // committed frames, wraps
  logic [7:0]  tx_cnt_q;                  // sent frames, wraps
  logic        len_err_q;                 // sticky framing error
  logic        len_err_set;               // framing fault this cycle
  wire         sel_ctrl = (reg_addr_i == DAP_REG_CTRL);
  wire         sel_stat = (reg_addr_i == DAP_REG_STAT);
  wire         sel_inst = (reg_addr_i == DAP_REG_INST);
  wire         wr_ctrl  = reg_wr_i & sel_ctrl;
  wire         clr_err  = reg_wr_i & sel_stat & reg_wdata_i[DAP_STAT_LENERR];
  wire         rx_en    = ctrl_q[0];
  wire         tx_en    = ctrl_q[1];
  logic        rx_in_frame_q;             // between byte 0 and byte 25

  wire [31:0] stat_word = {13'h0000, rx_in_frame_q, tx_busy_o, len_err_q, tx_cnt_q, rx_cnt_q};
  wire [31:0] rd_mux    = sel_ctrl ? {30'h00000000, ctrl_q} :
                          sel_stat ? stat_word :
                          sel_inst ? {16'h0000, DAP_IN_INST, DAP_OUT_INST} :
                          32'h00000000;   // unmapped reads as zero

  // control register
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ctrl_q <= DAP_CTRL_RESET;
    else if (wr_ctrl)
      ctrl_q <= reg_wdata_i[1:0];
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      reg_rdata_o <= 32'h00000000;
    else
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h00000000;
  end

  // sticky error: a new fault in the clear cycle wins
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      len_err_q <= 1'b0;
    else if (len_err_set)
      len_err_q <= 1'b1;
    else if (clr_err)
      len_err_q <= 1'b0;
  end

  // ==========================================================================
  // receive: output assembly unpack
  // ==========================================================================
  logic [4:0]    rx_idx_q;                // next byte index
  logic [NB-1:0] shadow_q;                // bytes gathered so far
  logic [NB-1:0] shadow_n;                // shadow with this cycle's byte
  dap_cmd_t      cmd_n;                   // decoded from shadow_n
  wire           rx_take  = rx_valid_i & rx_en;
  wire           rx_first = rx_take & rx_sof_i;
  wire           rx_more  = rx_take & ~rx_sof_i & rx_in_frame_q;
  wire           rx_wr    = rx_first | rx_more;
  wire [4:0]     rx_wix   = rx_first ? 5'h00 : rx_idx_q;
  wire           commit   = rx_more & (rx_idx_q == DAP_LAST_IDX);

  assign rx_ready_o = 1'b1;
  // short frame (new byte 0 mid-frame) or stray byte outside a frame
  assign len_err_set = (rx_first & rx_in_frame_q) | (rx_take & ~rx_sof_i & ~rx_in_frame_q);

  // one byte lane per frame position
  genvar gk;
  generate
    for (gk = 0; gk < DAP_ASM_BYTES; gk++)
    begin : g_lane
      wire hit = rx_wr & (rx_wix == 5'(gk));
      assign shadow_n[8*gk +: 8] = hit ? rx_data_i : shadow_q[8*gk +: 8];
    end
  endgenerate

  // field decode; byte 1 and spare bits of byte 0 are ignored
  assign cmd_n.run_forward                   = shadow_n[DAP_BIT_RUN_FWD];
  assign cmd_n.run_reverse                   = shadow_n[DAP_BIT_RUN_REV];
  assign cmd_n.fault_reset                   = shadow_n[DAP_BIT_FAULT_RST];
  assign cmd_n.control_from_network_select   = shadow_n[DAP_BIT_NET_CTL];
  assign cmd_n.reference_from_network_select = shadow_n[DAP_BIT_NET_REF];
  assign cmd_n.speed_ref  = shadow_n[8*DAP_BYTE_SPEED +: 16];
  assign cmd_n.torque_ref = shadow_n[8*DAP_BYTE_TORQUE +: 16];
  assign cmd_n.param      = shadow_n[NB-1 : 8*DAP_BYTE_PARAM];

  // shadow and frame tracking
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      shadow_q      <= '0;
      rx_idx_q      <= 5'h00;
      rx_in_frame_q <= 1'b0;
    end
    else if (rx_wr)
    begin
      shadow_q      <= shadow_n;
      rx_idx_q      <= rx_wix + 5'h01;
      rx_in_frame_q <= ~commit;
    end
  end

  // command updates only on a complete frame, so the drive never sees a torn one
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cmd_o       <= '0;
      cmd_valid_o <= 1'b0;
      rx_cnt_q    <= 8'h00;
    end
    else
    begin
      cmd_valid_o <= commit;
      if (commit)
      begin
        cmd_o    <= cmd_n;
        rx_cnt_q <= rx_cnt_q + 8'h01;
      end
    end
  end

  // ==========================================================================
  // transmit: input assembly pack
  // ==========================================================================
  typedef enum logic [0:0] {
    DAP_TX_IDLE = 1'b0,
    DAP_TX_SEND = 1'b1
  } dap_tx_st_t;

  dap_tx_st_t    tx_st_q;                 // loader state
  dap_tx_st_t    tx_st_d;                 // next state
  logic [4:0]    tx_idx_q;                // byte being loaded
  logic [NB-1:0] snap_q;                  // frozen status frame
  logic          buf_in_ready;            // buffer has room
  logic [9:0]    buf_out;                 // {sof, last, data}
  wire           tx_go    = (tx_st_q == DAP_TX_IDLE) & tx_start_i & tx_en;
  wire           tx_push  = (tx_st_q == DAP_TX_SEND) & buf_in_ready;
  wire           tx_lastb = (tx_idx_q == DAP_LAST_IDX);
  wire [7:0]     tx_byte  = snap_q[{tx_idx_q, 3'h0} +: 8];
  // whole-byte status layout, low byte of each word first
  wire [NB-1:0]  snap_n   = {sts_i.param, sts_i.torque_act, sts_i.speed_act,
                             sts_i.drive_state, sts_i[NB-1 -: 8]};

  // loader next state; a start during a frame is ignored
  always_comb
  begin
    tx_st_d = tx_st_q;
    case (tx_st_q)
      DAP_TX_IDLE: if (tx_go) tx_st_d = DAP_TX_SEND;
      DAP_TX_SEND: if (tx_push & tx_lastb) tx_st_d = DAP_TX_IDLE;
      default:     tx_st_d = DAP_TX_IDLE;
    endcase
  end

  // snapshot keeps the frame coherent while bytes drain slowly
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tx_st_q  <= DAP_TX_IDLE;
      tx_idx_q <= 5'h00;
      snap_q   <= '0;
      tx_cnt_q <= 8'h00;
    end
    else
    begin
      tx_st_q <= tx_st_d;
      if (tx_go)
      begin
        snap_q   <= snap_n;
        tx_idx_q <= 5'h00;
      end
      else if (tx_push)
        tx_idx_q <= tx_idx_q + 5'h01;
      if (tx_push & tx_lastb)
        tx_cnt_q <= tx_cnt_q + 8'h01;
    end
  end

  assign tx_busy_o = (tx_st_q == DAP_TX_SEND);

  // buffer absorbs a receiver stall; loader waits on its ready
  dap_skid_buf #(.W(10)) u_buf (
    .mclk_i      (mclk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (tx_busy_o),
    .in_ready_o  (buf_in_ready),
    .in_data_i   ({(tx_idx_q == 5'h00), tx_lastb, tx_byte}),
    .out_valid_o (tx_valid_o),
    .out_ready_i (tx_ready_i),
    .out_data_o  (buf_out)
  );

  assign tx_sof_o  = buf_out[9];
  assign tx_last_o = buf_out[8];
  assign tx_data_o = buf_out[7:0];

  // ==========================================================================
  // checks
  // ==========================================================================
  sequence s_commit;
    commit;
  endsequence

  sequence s_capture;
    tx_go;
  endsequence

  chk_frame_length: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    rx_wr |=> (rx_idx_q <= 5'h1A) && (rx_in_frame_q == (rx_idx_q != 5'h1A)))
    else $error("receive index ran past the frame");

  chk_ctrl_bits: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    s_commit |=> cmd_valid_o && cmd_o.run_forward == $past(shadow_n[0])
      && cmd_o.reference_from_network_select == $past(shadow_n[6]))
    else $error("byte 0 control bits decoded wrongly");

  chk_speed_ref: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    s_commit |=> cmd_o.speed_ref == {$past(shadow_n[31:24]), $past(shadow_n[23:16])})
    else $error("speed reference bytes misplaced");

  chk_torque_ref: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    s_commit |=> cmd_o.torque_ref == $past(shadow_n[47:32]))
    else $error("torque reference bytes misplaced");

  chk_param_ends: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    s_commit |=> cmd_o.param[9][15:8] == $past(rx_data_i)
      && cmd_o.param[0] == $past(shadow_n[63:48]))
    else $error("parameter words misplaced");

  chk_hold_between: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    !commit |=> $stable(cmd_o) && !cmd_valid_o)
    else $error("command changed without a complete frame");

  chk_status_byte: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    s_capture |=> snap_q[7:0] == {$past(sts_i.at_reference), $past(sts_i.ref_from_net),
      $past(sts_i.ctrl_from_net), $past(sts_i.ready), $past(sts_i.running_reverse),
      $past(sts_i.running_forward), $past(sts_i.warning), $past(sts_i.faulted)})
    else $error("status byte packed wrongly");

  chk_state_speed: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    s_capture |=> snap_q[15:8] == $past(sts_i.drive_state)
      && snap_q[31:16] == $past(sts_i.speed_act) && snap_q[47:32] == $past(sts_i.torque_act))
    else $error("state, speed or torque packed wrongly");

  chk_first_byte: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    s_capture ##1 buf_in_ready |-> tx_idx_q == 5'h00 && tx_byte == snap_q[7:0])
    else $error("frame does not start at byte 0");

  chk_err_sticky: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    len_err_set |=> len_err_q)
    else $error("framing error not held");

  chk_rx_gated: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    rx_valid_i && !rx_en |=> $stable(rx_idx_q) && $stable(rx_in_frame_q))
    else $error("byte taken while receive disabled");

  chk_snap_hold: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    tx_busy_o |=> $stable(snap_q))
    else $error("snapshot changed during a frame");

  chk_tx_params: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    s_capture |=> snap_q[NB-1 -: 16] == $past(sts_i.param[9])
      && snap_q[63:48] == $past(sts_i.param[0]))
    else $error("input parameter words packed wrongly");

  chk_tx_end: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    tx_push && tx_lastb |=> !tx_busy_o)
    else $error("loader ran past byte 25");

  chk_tx_marks: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    tx_valid_o && tx_sof_o |-> !tx_last_o)
    else $error("first and last markers on one byte");

endmodule

/* dap_net_model.sv */
// network controller model: sends output assemblies, takes input assemblies
`timescale 1ns/100ps
module dap_net_model
  import dap_pkg::*;
(
  input  wire logic       mclk_i,     // system clock
  input  wire logic       slow_i,     // stall the input stream
  output logic            rx_valid_o, // byte offered to block
  output logic            rx_sof_o,   // byte 0 marker
  output logic [7:0]      rx_data_o,  // byte value
  input  wire logic       tx_valid_i, // block offers a byte
  input  wire logic [7:0] tx_data_i,  // byte value
  input  wire logic       tx_sof_i,   // byte 0 marker
  input  wire logic       tx_last_i,  // byte 25 marker
  output logic            tx_ready_o  // model takes the byte
);
  logic [9:0] got_q [$];              // captured {last, sof, data}
  logic [1:0] ph_q;                   // stall phase

  initial
  begin
    rx_valid_o = 1'b0;
    rx_sof_o   = 1'b0;
    rx_data_o  = 8'h00;
    tx_ready_o = 1'b1;
    ph_q       = 2'h0;
  end

  // ==========================================================================
  // output assembly sender
  // ==========================================================================
  // bytes go out in index order, words low byte first as the table lays them
  task automatic send(input logic [25:0][7:0] f, input int n, input int gap, input bit sof);
    for (int i = 0; i < n; i++)
    begin
      @(posedge mclk_i);
      rx_valid_o <= 1'b1;
      rx_sof_o   <= sof && (i == 0);
      rx_data_o  <= f[i];
      if (gap > 0 && i < n - 1)
      begin
        // idle line shows garbage, never the last byte
        @(posedge mclk_i);
        rx_valid_o <= 1'b0;
        rx_data_o  <= ~f[i];
        repeat (gap - 1) @(posedge mclk_i);
      end
    end
    @(posedge mclk_i);
    rx_valid_o <= 1'b0;
    rx_sof_o   <= 1'b0;
    rx_data_o  <= ~f[n-1];
  endtask

  // ==========================================================================
  // input assembly receiver
  // ==========================================================================
  // slow mode takes one byte in four so the buffer fills and must hold
  always @(posedge mclk_i)
  begin
    if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1)
      got_q.push_back({tx_last_i, tx_sof_i, tx_data_i});
    ph_q       <= ph_q + 2'h1;
    tx_ready_o <= !slow_i || (ph_q == 2'h3);
  end
endmodule

/* dap_top_tb.sv */
// testbench: drive assembly packer against the network controller model
`timescale 1ns/100ps
module dap_top_tb
  import dap_pkg::*;
;
  typedef logic [25:0][7:0] dap_frm_t;        // one assembly, byte i at [i]
  logic        mclk_i;                        // system clock
  logic        reset_n_i;                     // async reset, active low
  logic        slow_i;                        // model stalls input stream
  logic        rx_valid_i;                    // model byte valid
  logic        rx_sof_i;                      // model byte 0 marker
  logic [7:0]  rx_data_i;                     // model byte
  logic        rx_ready_o;                    // block ready
  dap_cmd_t    cmd_o;                         // unpacked command
  logic        cmd_valid_o;                   // command update pulse
  dap_sts_t    sts_i;                         // drive status
  logic        tx_start_i;                    // send request
  logic        tx_valid_o;                    // block byte valid
  logic        tx_ready_i;                    // model takes byte
  logic [7:0]  tx_data_o;                     // block byte
  logic        tx_sof_o;                      // byte 0 marker
  logic        tx_last_o;                     // byte 25 marker
  logic        tx_busy_o;                     // loader busy
  logic [3:0]  reg_addr_i;                    // register address
  logic [31:0] reg_wdata_i;                   // register write data
  logic        reg_wr_i;                      // write strobe
  logic        reg_rd_i;                      // read strobe
  logic [31:0] reg_rdata_o;                   // read data
  int          miscompares;                   // mismatch count
  int          total_checks;                  // comparison count
  int          pulses;                        // command updates seen
  int          cycles;                        // hang guard

  dap_top dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .rx_valid_i(rx_valid_i),
    .rx_sof_i(rx_sof_i), .rx_data_i(rx_data_i), .rx_ready_o(rx_ready_o), .cmd_o(cmd_o),
    .cmd_valid_o(cmd_valid_o), .sts_i(sts_i), .tx_start_i(tx_start_i), .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o), .tx_sof_o(tx_sof_o), .tx_last_o(tx_last_o),
    .tx_busy_o(tx_busy_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));

  dap_net_model net (.mclk_i(mclk_i), .slow_i(slow_i), .rx_valid_o(rx_valid_i),
    .rx_sof_o(rx_sof_i), .rx_data_o(rx_data_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
    .tx_sof_i(tx_sof_o), .tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i));

  // ==========================================================================
  // clock, monitors and shared tasks
  // ==========================================================================
  initial
  begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  // counts update pulses; a stuck or doubled pulse shows as a wrong count
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cmd_valid_o === 1'b1)
      pulses++;
    if (cycles == 5000)
    begin
      miscompares++;
      results();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i    <= 1'b0;
  endtask

  // data stands in the cycle after the strobe, taken at that cycle's closing edge
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i   <= 1'b0;
    @(posedge mclk_i);
    d = reg_rdata_o;
  endtask

  // distinct bytes; byte 1 all ones since it must be ignored
  function automatic dap_frm_t mk(input logic [7:0] b0, input logic [7:0] s);
    dap_frm_t f;
    for (int i = 0; i < 26; i++)
      f[i] = 8'(i * 29) ^ s;
    f[0] = b0;
    f[1] = 8'hFF;
    return f;
  endfunction

  task automatic check_cmd(input dap_frm_t f);
    check("cmd_bits", 32'({cmd_o.run_forward, cmd_o.run_reverse, cmd_o.fault_reset,
      cmd_o.control_from_network_select, cmd_o.reference_from_network_select}),
      32'({f[0][0], f[0][1], f[0][2], f[0][5], f[0][6]}));
    check("speed_ref", 32'(cmd_o.speed_ref), 32'({f[3], f[2]}));
    check("torque_ref", 32'(cmd_o.torque_ref), 32'({f[5], f[4]}));
    for (int k = 0; k < 10; k++)
      check("param_out", 32'(cmd_o.param[k]), 32'({f[7+2*k], f[6+2*k]}));
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_regs();
    logic [31:0] d;
    check("cmd_reset", 32'(cmd_o.speed_ref), 32'h0);
    check("rx_ready", 32'(rx_ready_o), 32'h1);
    reg_rd(DAP_REG_INST, d);
    check("inst", d, 32'h0000AD7B);
    reg_rd(DAP_REG_CTRL, d);
    check("ctrl", d, 32'h00000003);
    reg_rd(4'hC, d);
    check("unmapped", d, 32'h0);
  endtask

  // full frame, gapped or back to back; exactly one update pulse
  task automatic t_rx(input dap_frm_t f, input int gap);
    int p;
    p = pulses;
    net.send(f, 26, gap, 1'b1);
    repeat (3) @(posedge mclk_i);
    check("pulses", 32'(pulses - p), 32'h1);
    check_cmd(f);
  endtask

  // abandoned partial frame, then a stray byte; error sticky and cleared by one
  task automatic t_err();
    logic [31:0] d;
    dap_frm_t    g;
    g = mk(8'h07, 8'h3C);
    net.send(mk(8'h00, 8'h11), 5, 0, 1'b1);
    t_rx(g, 0);
    reg_rd(DAP_REG_STAT, d);
    check("err_set", 32'(d[DAP_STAT_LENERR]), 32'h1);
    reg_wr(DAP_REG_STAT, 32'h00010000);
    reg_rd(DAP_REG_STAT, d);
    check("err_clr", 32'(d[DAP_STAT_LENERR]), 32'h0);
    net.send(g, 1, 0, 1'b0);
    reg_rd(DAP_REG_STAT, d);
    check("err_stray", 32'(d[DAP_STAT_LENERR]), 32'h1);
    check_cmd(g);
  endtask

  // stalled receiver, second start while busy must be dropped
  task automatic t_tx();
    logic [9:0][15:0] prm;
    logic [7:0]       e [26];
    for (int k = 0; k < 10; k++)
    begin
      prm[k]     = 16'hC000 | 16'(k * 16'h0111);
      e[6+2*k]   = prm[k][7:0];
      e[7+2*k]   = prm[k][15:8];
    end
    {e[0], e[1], e[2], e[3], e[4], e[5]} = {8'hA5, 8'h3C, 8'h34, 8'h12, 8'hEF, 8'hBE};
    net.got_q.delete();
    slow_i <= 1'b1;
    sts_i  <= {8'hA5, 8'h3C, 16'h1234, 16'hBEEF, prm};
    @(posedge mclk_i);
    tx_start_i <= 1'b1;
    @(posedge mclk_i);
    tx_start_i <= 1'b0;
    @(posedge mclk_i);
    check("busy", 32'(tx_busy_o), 32'h1);
    tx_start_i <= 1'b1;
    @(posedge mclk_i);
    tx_start_i <= 1'b0;
    for (int c = 0; c < 400 && net.got_q.size() < 26; c++)
      @(posedge mclk_i);
    repeat (40) @(posedge mclk_i);
    check("tx_count", 32'(net.got_q.size()), 32'd26);
    for (int i = 0; i < 26 && i < net.got_q.size(); i++)
      check("tx_byte", 32'(net.got_q[i]), 32'({i == 25, i == 0, e[i]}));
    slow_i <= 1'b0;
  endtask

  // both directions disabled: nothing taken, nothing sent
  task automatic t_off();
    int          p;
    logic [31:0] d;
    p = pulses;
    net.got_q.delete();
    reg_wr(DAP_REG_CTRL, 32'h0);
    net.send(mk(8'h61, 8'h5A), 26, 0, 1'b1);
    @(posedge mclk_i);
    tx_start_i <= 1'b1;
    @(posedge mclk_i);
    tx_start_i <= 1'b0;
    repeat (60) @(posedge mclk_i);
    check("off_pulses", 32'(pulses - p), 32'h0);
    check("off_tx", 32'(net.got_q.size()), 32'h0);
    reg_rd(DAP_REG_STAT, d);
    check("stat_cnt", 32'(d[15:0]), 32'h0103);
    reg_wr(DAP_REG_CTRL, 32'h3);
  endtask

  task automatic results();
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial
  begin
    reset_n_i   = 1'b0;
    slow_i      = 1'b0;
    sts_i       = '0;
    tx_start_i  = 1'b0;
    reg_addr_i  = 4'h0;
    reg_wdata_i = 32'h0;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    repeat (4) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    t_regs();
    t_rx(mk(8'hB9, 8'hA5), 2);
    t_rx(mk(8'h46, 8'h5C), 0);
    t_err();
    t_tx();
    t_off();
    t_rx(mk(8'h21, 8'h0F), 1);
    results();
  end
endmodule
